// File: core/sxc_pkg.sv
/*
 * package for the serial crosspoint switch control block: field layout of
 * the five-bit load word, switch count, address map of the axi4-lite
 * register file and bus response codes.
 * assumes: nothing beyond a systemverilog compiler.
 */
package sxc_pkg;

    // ********************************************************************
    // load word layout
    // ********************************************************************
    localparam int unsigned WORD_W    = 5;  // bits held by the shift register
    localparam int unsigned STATE_BIT = 4;  // switch-state bit (msb)
    localparam int unsigned LINE_BIT  = 3;  // input line select bit
    localparam int unsigned OSEL_HI   = 2;  // output select, top bit
    localparam int unsigned OSEL_LO   = 0;  // output select, bottom bit
    localparam int unsigned OSEL_W    = 3;  // output select width
    localparam int unsigned NSW       = 16; // number of crosspoints
    localparam int unsigned NOUT      = 8;  // outputs per input line
    localparam int unsigned IDX_W     = 4;  // crosspoint index width

    // line select value that addresses the first input line
    localparam logic        LINE_A    = 1'h1;

    // ********************************************************************
    // register map (byte addresses)
    // ********************************************************************
    localparam int unsigned AW        = 4;
    localparam logic [AW-1:0] ADDR_CTRL   = 4'h0; // load port drive
    localparam logic [AW-1:0] ADDR_SHIFT  = 4'h4; // shift register view
    localparam logic [AW-1:0] ADDR_SWITCH = 4'h8; // crosspoint states
    localparam logic [AW-1:0] ADDR_COUNT  = 4'hc; // updates taken

    // control register bit positions
    localparam int unsigned CTRL_EN1N = 0; // first load enable, active low
    localparam int unsigned CTRL_EN2N = 1; // second load enable, active low
    localparam int unsigned CTRL_CLK  = 2; // shift clock level
    localparam int unsigned CTRL_DATA = 3; // serial data level
    localparam int unsigned CTRL_W    = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h3; // enables high, idle

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : sxc_pkg

// File: core/sxc_engine.sv
/*
 * sxc_engine: the load engine of the crosspoint control.  the serial port
 * levels are sampled on aclk; falling shift clock edges with both enables low shift data in,
 * rising load enable edges update the addressed crosspoint latch.
 * assumes: port levels already synchronous to aclk (the top drives them
 * from its own registers), aresetn synchronous active low.
 */
`timescale 1ns/1ps

module sxc_engine
    import sxc_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              shift_clock,  // serial shift clock level
    input  wire logic              sdata,        // serial data level
    input  wire logic              load_en1_n,   // first load enable
    input  wire logic              load_en2_n,   // second load enable
    output logic [WORD_W-1:0]      shreg_q,      // shift register
    output logic [NSW-1:0]         xpt_q,        // crosspoint latches
    output logic                   upd_q         // one-cycle update pulse
);

    // ********************************************************************
    // edge detection
    // ********************************************************************
    logic             clk_prev_q;    // previous shift clock level
    logic             en1_prev_q;    // previous first enable
    logic             en2_prev_q;    // previous second enable
    logic             fall;          // shift clock falling edge
    logic             rise;          // either enable rising
    logic             loading;       // both enables low
    logic [IDX_W-1:0] idx;           // addressed crosspoint
    logic [OSEL_W-1:0] osel;         // output select field

    // previous-level registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_prev_q <= 1'b0;
            en1_prev_q <= 1'b1;
            en2_prev_q <= 1'b1;
        end else begin
            clk_prev_q <= shift_clock;
            en1_prev_q <= load_en1_n;
            en2_prev_q <= load_en2_n;
        end
    end

    assign fall    = clk_prev_q & ~shift_clock;              // see RULE4
    assign loading = ~load_en1_n & ~load_en2_n;              // see RULE1
    assign rise    = (~en1_prev_q & load_en1_n)
                   | (~en2_prev_q & load_en2_n);             // see RULE6

    // ********************************************************************
    // address decode: output code is inverted, bit-reversed output number
    // ********************************************************************
    // 111 -> out1 ... 000 -> out8; bits read x2 x1 x0 with x2 weight 1
    assign osel = ~{shreg_q[OSEL_LO], shreg_q[OSEL_LO+1], shreg_q[OSEL_HI]};
    // first line occupies indices 0..7, second 8..15
    assign idx  = {(shreg_q[LINE_BIT] != LINE_A), osel};     // see RULE10 RULE11

    // shift register: msb-first word, oldest bits fall off the top
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shreg_q <= '0;
        end else if (fall && loading) begin                  // see RULE1
            shreg_q <= {shreg_q[WORD_W-2:0], sdata};         // see RULE2 RULE3 RULE5
        end
    end

    // one latch per crosspoint, only the addressed one updates
    generate
        for (genvar i = 0; i < NSW; i++) begin : g_xpt
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    xpt_q[i] <= 1'b0;                        // all open
                end else if (rise && idx == IDX_W'(i)) begin // see RULE6 RULE9
                    xpt_q[i] <= shreg_q[STATE_BIT];          // see RULE7
                end                                          // see RULE8
            end
        end
    endgenerate

    // update pulse for the counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upd_q <= 1'b0;
        end else begin
            upd_q <= rise;
        end
    end

endmodule : sxc_engine

// File: core/sxc_top.sv
/*
 * sxc_top: control logic of a two-line by eight-output crosspoint switch.
 * software drives the serial load port levels through an axi4-lite
 * register, and reads back the shift register and all sixteen latches.
 * the latches also leave the block through a register to steer the analog switches.
 * assumes: single 200 mhz clock aclk, synchronous active-low aresetn,
 * an axi4-lite master issuing at most one write and one read at a time.
 */
// Design decisions made here: register access over AXI4-Lite and the register addresses.
//
// Summary of operation
// (RULE1) shift five bits while both enables low
// (RULE2) word is state, line, three output bits
// (RULE3) state bit shifted first, output lsb last
// (RULE4) data sampled on shift clock falling edge
// (RULE5) extra shifts keep last five bits only
// (RULE6) enable rise updates addressed latch only
// (RULE7) state one closes, zero opens switch
// (RULE8) each latch holds until readdressed
// (RULE9) any crosspoint combination may be closed
// (RULE10) line bit one is first input
// (RULE11) output code 111 is output one, etc
// (RULE12) controller sends extra bit as one
//
`timescale 1ns/1ps

module sxc_top
    import sxc_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // write address channel
    input  wire logic [31:0]       s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // write data channel
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // write response channel
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // read address channel
    input  wire logic [31:0]       s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // read data channel
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // crosspoint drive, bit 8*line+(output-1), line 0 is the first
    output logic [NSW-1:0]         xpt_closed_q
);

    // ********************************************************************
    // internal state
    // ********************************************************************
    logic [CTRL_W-1:0] ctrl_q;      // serial port drive levels
    logic [WORD_W-1:0] shreg;       // engine shift register
    logic [NSW-1:0]    xpt;         // engine latches
    logic              upd;         // engine update pulse
    logic [15:0]       count_q;     // updates taken, wraps
    logic              aw_held_q;   // write address captured
    logic              w_held_q;    // write data captured
    logic [AW-1:0]     awaddr_q;    // captured write address
    logic [31:0]       wdata_q;     // captured write data
    logic [3:0]        wstrb_q;     // captured strobes
    logic              wr_go;       // both halves present
    logic [31:0]       rd_mux;      // read data selection
    logic              rd_hit;      // read address decodes

    // ********************************************************************
    // load engine
    // ********************************************************************
    sxc_engine u_engine (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .shift_clock (ctrl_q[CTRL_CLK]),
        .sdata       (ctrl_q[CTRL_DATA]),
        .load_en1_n  (ctrl_q[CTRL_EN1N]),
        .load_en2_n  (ctrl_q[CTRL_EN2N]),
        .shreg_q     (shreg),
        .xpt_q       (xpt),
        .upd_q       (upd)
    );

    // latches leave through a register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xpt_closed_q <= '0;
        end else begin
            xpt_closed_q <= xpt;                             // see RULE9
        end
    end

    // update counter, read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= '0;
        end else if (upd) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // ********************************************************************
    // axi write path
    // ********************************************************************
    assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

    // address capture; ready while nothing held and no write answer pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            awaddr_q      <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr[AW-1:0];
            s_axi_awready <= 1'b0;
        end else if (wr_go) begin
            aw_held_q     <= 1'b0;
        end else if (!aw_held_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    // data capture, independent of address order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q     <= 1'b0;
            wdata_q      <= '0;
            wstrb_q      <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_go) begin
            w_held_q     <= 1'b0;
        end else if (!w_held_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // control register write; only the low byte matters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_go && awaddr_q == ADDR_CTRL && wstrb_q[0]) begin
            ctrl_q <= wdata_q[CTRL_W-1:0];                   // see RULE3 RULE12
        end
    end

    // write response: slverr for unmapped or read-only targets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == ADDR_CTRL) ? RESP_OKAY
                                                    : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ********************************************************************
    // axi read path
    // ********************************************************************
    // read data selection from the live read address
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = '0;
        unique case (s_axi_araddr[AW-1:0])
            ADDR_CTRL:   rd_mux[CTRL_W-1:0] = ctrl_q;
            ADDR_SHIFT:  rd_mux[WORD_W-1:0] = shreg;
            ADDR_SWITCH: rd_mux[NSW-1:0]    = xpt;
            ADDR_COUNT:  rd_mux[15:0]       = count_q;
            default:     rd_hit             = 1'b0;
        endcase
    end

    // read address ready while no answer is outstanding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : sxc_top

// File: testbench/sxc_props_properties.sv
/* sxc_props: bus handshake and crosspoint checks on the ports of sxc_top.
 * assumes: bound to sxc_top, one clock aclk, aresetn sync active low. */
`timescale 1ns/1ps
module sxc_props
    import sxc_pkg::*;
(
    input wire logic           aclk,
    input wire logic           aresetn,
    input wire logic           s_axi_awready,
    input wire logic           s_axi_wready,
    input wire logic [1:0]     s_axi_bresp,
    input wire logic           s_axi_bvalid,
    input wire logic           s_axi_bready,
    input wire logic [31:0]    s_axi_araddr,
    input wire logic           s_axi_arvalid,
    input wire logic           s_axi_arready,
    input wire logic [31:0]    s_axi_rdata,
    input wire logic [1:0]     s_axi_rresp,
    input wire logic           s_axi_rvalid,
    input wire logic           s_axi_rready,
    input wire logic [NSW-1:0] xpt_closed_q
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic bv_q;    // bvalid one edge back
    logic bv_rise; // write answer just raised

    // **********************************************************
    // helper: marks the edge that raised a write answer
    // **********************************************************
    always_ff @(posedge aclk) begin
        bv_q <= s_axi_bvalid;
    end
    assign bv_rise = s_axi_bvalid && !bv_q;

    read_answer_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr[1:0] == 2'h0 |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY)
        else $error("read answer late or not okay");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    write_block_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    write_free_a: assert property (s_axi_bvalid && s_axi_bready
        |=> ##[0:2] s_axi_awready && s_axi_wready)
        else $error("write channels not freed");
    xpt_cause_a: assert property ($changed(xpt_closed_q)
        |-> $past(bv_rise, 2) || $past(bv_rise, 3) || $past(bv_rise, 4))
        else $error("crosspoint changed without a load write");
    xpt_single_a: assert property ($changed(xpt_closed_q)
        |-> $onehot(xpt_closed_q ^ $past(xpt_closed_q)))
        else $error("more than one crosspoint changed");
endmodule : sxc_props

// File: testbench/sxc_host.sv
/* sxc_host: axi4-lite master acting as the controller that loads words.
 * assumes: aclk from the bench, slave answers by its own handshake. */
`timescale 1ns/1ps
module sxc_host
    import sxc_pkg::*;
(
    input  wire logic        aclk,
    output logic [31:0]      s_axi_awaddr,
    output logic [2:0]       s_axi_awprot,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [31:0]      s_axi_araddr,
    output logic [2:0]       s_axi_arprot,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    logic slow; // accept answers only a cycle after they appear

    // **********************************************************
    // idle levels at time zero
    // **********************************************************
    initial begin
        {s_axi_awaddr, s_axi_awprot, s_axi_awvalid} = '0;
        {s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        slow = 1'h0;
    end

    // one write: address and data offered together, each freed when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic done;
        done = 1'h0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= !slow;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                done = 1'h1;
                s_axi_bready <= 1'h0;
            end else if (s_axi_bvalid) s_axi_bready <= 1'h1;
        end
        @(posedge aclk);
    endtask : wr

    // one read, answer held until rready is seen
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic done;
        done = 1'h0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= !slow;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                done = 1'h1;
                s_axi_rready <= 1'h0;
            end else if (s_axi_rvalid) s_axi_rready <= 1'h1;
        end
        @(posedge aclk);
    endtask : rd

    // shift n bits msb first with enables low, then raise enables m;
    // data is inverted while the clock is high so only the fall counts
    task automatic load(input logic [7:0] w, input int n,
                        input logic [1:0] m);
        logic [1:0] r;
        wr({28'h0, ADDR_CTRL}, 32'h0, r);
        for (int i = n - 1; i >= 0; i--) begin
            wr({28'h0, ADDR_CTRL}, {28'h0, !w[i], 3'h4}, r);
            wr({28'h0, ADDR_CTRL}, {28'h0, w[i], 3'h0}, r);
        end
        wr({28'h0, ADDR_CTRL}, {30'h0, m}, r); // raise enables
    endtask : load
endmodule : sxc_host

// File: testbench/tb_top.sv
/* tb_top: loads crosspoint words through the host model and compares
 * the shift register, latches, update count and switch pins.
 * assumes: sxc_top, sxc_host and sxc_props compiled before it. */
`timescale 1ns/1ps
module tb_top;
    import sxc_pkg::*;
    localparam logic [19:0] SEQ = 20'hbfbae; // ctrl writes, low nibble first
    logic            aclk, aresetn;
    logic [31:0]     s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [2:0]      s_axi_awprot, s_axi_arprot;
    logic [3:0]      s_axi_wstrb;
    logic [1:0]      s_axi_bresp, s_axi_rresp, resp;
    logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic            s_axi_rvalid, s_axi_rready;
    logic [NSW-1:0]  xpt_closed_q;
    logic [31:0]     rdat;          // last read data
    logic [15:0]     exp_sw;        // expected latches
    logic [15:0]     exp_cnt;       // expected update count
    logic [2:0]      outc [8];      // output code per output number
    int              failures, total_checks;

    sxc_top  u_dut  (.*);
    sxc_host u_host (.*);

    initial aclk = 1'h0;
    always #2.5 aclk = !aclk;

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t resp %h expected %h", $time, got, exp);
        end
    endtask : chk_resp

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        u_host.rd({28'h0, a}, rdat, resp);
        chk_resp(resp, RESP_OKAY);
        chk_val(rdat, exp);
    endtask : rdchk

    task automatic ld(input logic [7:0] w, input int n, input logic [1:0] m);
        u_host.load(w, n, m);
        exp_cnt++;
    endtask : ld

    task automatic results;
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // **********************************************************
    // main sequence and watchdog
    // **********************************************************
    initial begin
        outc = '{3'h7, 3'h3, 3'h5, 3'h1, 3'h6, 3'h2, 3'h4, 3'h0};
        failures = 0;
        total_checks = 0;
        exp_sw = 16'h0;
        exp_cnt = 16'h0;
        aresetn = 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rdchk(ADDR_CTRL, 32'h3);
        rdchk(ADDR_SHIFT, 32'h0);
        rdchk(ADDR_SWITCH, 32'h0);
        // close each crosspoint in turn, enables rising one, other, both
        for (int k = 0; k < 16; k++) begin
            // a leading R bit of one falls off the five-bit register
            ld({2'h0, 1'h1, 1'h1, k < 8, outc[k % 8]}, 6,
               2'(k % 3 + 1));
            exp_sw[k] = 1'h1;
            rdchk(ADDR_SWITCH, {16'h0, exp_sw});
            chk_val({16'h0, xpt_closed_q}, {16'h0, exp_sw});
        end
        rdchk(ADDR_SHIFT, 32'h10);
        ld(8'h0e, 5, 2'h3);
        exp_sw[4] = 1'h0;
        rdchk(ADDR_SWITCH, {16'h0, exp_sw});
        ld(8'hcf, 8, 2'h2);
        exp_sw[0] = 1'h0;
        rdchk(ADDR_SHIFT, 32'hf);
        rdchk(ADDR_SWITCH, {16'h0, exp_sw});
        // clock toggles with an enable high must not shift
        for (int i = 0; i < 5; i++) begin
            u_host.wr({28'h0, ADDR_CTRL}, {28'h0, SEQ[4*i +: 4]}, resp);
        end
        exp_cnt++;
        rdchk(ADDR_SHIFT, 32'hf);
        rdchk(ADDR_COUNT, {16'h0, exp_cnt});
        u_host.slow = 1'h1;
        u_host.wr({28'h0, ADDR_SWITCH}, 32'h0, resp);
        chk_resp(resp, RESP_SLVERR);
        rdchk(ADDR_SWITCH, {16'h0, exp_sw});
        u_host.slow = 1'h0;
        rdchk(ADDR_CTRL, 32'hb);
        // unaligned read address decodes to nothing
        u_host.rd(32'h2, rdat, resp);
        chk_resp(resp, RESP_SLVERR);
        chk_val(rdat, 32'h0);
        // mid-run reset clears latches and counter, returns control levels to idle
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rdchk(ADDR_CTRL, 32'h3);
        rdchk(ADDR_SWITCH, 32'h0);
        chk_val({16'h0, xpt_closed_q}, 32'h0);
        rdchk(ADDR_COUNT, 32'h0);
        results();
    end

    initial begin
        #50000;
        failures++;
        results();
    end
endmodule : tb_top

bind sxc_top sxc_props u_props (.*);
